/* ccd_decode_timer.sv */
/*
  Decode and timing of the compare, decimal arithmetic, decrement and divide
  slice: operand selection, instruction length and execution cycle count.
  Assumes fetch presents one decoded instruction with a one-cycle issue pulse
  and that the datapath signals an early divide finish when it has one.
*/
// What this block does
// - General compare has one size bit (0 byte, 1 word) and two 4-bit fields.
// - Codes 0-3 pick data registers: byte halves of first two, or four words.
// - Codes 4,5 pick address registers; 6,7 indirect through them.
// - Codes 8-15 pick 8/16-bit displacements from bases, or absolute.
// - General compare is 2, 3 or 4 cycles for zero, one, two memory operands.
// - General compare length is 2 plus each operand's displacement or absolute address bytes.
// - Short compare: 2-bit source code, 1-bit accumulator half destination.
// - Short compare takes 1/2, 2/3 or 3/3 bytes/cycles by source kind.
// - Decimal add with carry takes 5 cycles; 3, 4 or 2 bytes.
// - Decimal add takes 5 cycles; 3, 4 or 2 bytes.
// - Decimal subtract with borrow takes 4 cycles; 3, 4 or 2 bytes.
// - Byte decrement 3-bit codes, 1/1, 2/3, 3/3; word decrement 1/1.
// - Signed divide immediate is 3/22, word adds one byte and six cycles.
// - Signed divide general source 22 or 24 cycles, word adds six.
// - Unsigned divide immediate is 3/18, word adds one byte, seven cycles.
// - Unsigned divide general source 18 or 20 cycles, word adds seven.
// - Divide counts are upper bounds; early finish is allowed.
`timescale 1ns/1ns
`default_nettype none

module ccd_decode_timer (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Instruction from fetch
  input  wire logic             issue_in,
  input  wire logic [3:0]       op_in,
  input  wire logic             word_in,
  input  wire logic             imm_in,
  input  wire logic [3:0]       src_code_in,
  input  wire logic [3:0]       dst_code_in,
  // Datapath feedback
  input  wire logic             early_done_in,
  // Timing results
  output logic                  busy_out,
  output logic                  done_out,
  output logic [2:0]            bytes_out,
  output logic [4:0]            cycles_out,
  output logic                  writes_dest_out,
  output logic                  bad_code_out,
  // Operand selection
  output ccd_pkg::ccd_kind_e    src_kind_out,
  output logic [1:0]            src_sel_out,
  output logic                  src_high_out,
  output ccd_pkg::ccd_kind_e    dst_kind_out,
  output logic [1:0]            dst_sel_out,
  output logic                  dst_high_out
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ccd_state_e;

  typedef struct packed {
    ccd_state_e         st;
    logic [4:0]         left;
    logic               is_div;
    logic               done;
    logic [2:0]         bytes;
    logic [4:0]         cycles;
    logic               writes_dest;
    logic               bad_code;
    ccd_pkg::ccd_kind_e src_kind;
    logic [1:0]         src_sel;
    logic               src_high;
    ccd_pkg::ccd_kind_e dst_kind;
    logic [1:0]         dst_sel;
    logic               dst_high;
  } ccd_s;

  ccd_s               state_reg;
  ccd_s               state_next;
  ccd_pkg::ccd_kind_e gsrc_kind;
  logic [1:0]         gsrc_sel;
  logic               gsrc_high;
  ccd_pkg::ccd_kind_e gdst_kind;
  logic [1:0]         gdst_sel;
  logic               gdst_high;
  logic               take;

  // General operand fields, shared by compare and divide source
  ccd_operand_decode u_src_decode (
    .code_in  (src_code_in),
    .word_in  (word_in),
    .kind_out (gsrc_kind),
    .sel_out  (gsrc_sel),
    .high_out (gsrc_high)
  );

  ccd_operand_decode u_dst_decode (
    .code_in  (dst_code_in),
    .word_in  (word_in),
    .kind_out (gdst_kind),
    .sel_out  (gdst_sel),
    .high_out (gdst_high)
  );

  // Fetch may only issue while idle; a pulse during execution is dropped
  assign take = issue_in && (state_reg.st == ST_IDLE);

  // Decode on issue, then count the execution down
  always_comb begin
    logic [2:0] len;
    logic [4:0] cyc;
    len = 3'h0;
    cyc = 5'h00;
    state_next = state_reg;
    state_next.done = 1'b0;
    if (take) begin
      state_next.bad_code    = 1'b0;
      state_next.is_div      = 1'b0;
      state_next.writes_dest = 1'b1;
      state_next.src_kind    = ccd_pkg::KIND_NONE;
      state_next.src_sel     = 2'h0;
      state_next.src_high    = 1'b0;
      state_next.dst_kind    = ccd_pkg::KIND_DATA;   // Accumulator by default
      state_next.dst_sel     = 2'h0;
      state_next.dst_high    = 1'b0;
      case (op_in)
        ccd_pkg::COMPARE_G_OP: begin
          state_next.src_kind    = gsrc_kind;
          state_next.src_sel     = gsrc_sel;
          state_next.src_high    = gsrc_high;
          state_next.dst_kind    = gdst_kind;
          state_next.dst_sel     = gdst_sel;
          state_next.dst_high    = gdst_high;
          state_next.writes_dest = 1'b0;
          len = 3'(ccd_pkg::BYTES_TWO + ccd_pkg::ext_bytes(gsrc_kind)
                   + ccd_pkg::ext_bytes(gdst_kind));
          cyc = 5'(ccd_pkg::CYC_CMP_REG + ccd_pkg::is_mem(gsrc_kind)
                   + ccd_pkg::is_mem(gdst_kind));
        end
        ccd_pkg::COMPARE_S_OP: begin
          state_next.writes_dest = 1'b0;
          state_next.dst_high    = dst_code_in[0];
          case (src_code_in[1:0])
            ccd_pkg::SHORT_SRC_REG: begin
              state_next.src_kind = ccd_pkg::KIND_DATA;
              state_next.src_high = !dst_code_in[0];           // The other half
              len = ccd_pkg::BYTES_ONE;
              cyc = ccd_pkg::CYC_CMP_REG;
            end
            ccd_pkg::SHORT_SRC_STATIC, ccd_pkg::SHORT_SRC_FRAME: begin
              state_next.src_kind = ccd_pkg::KIND_DSP8;
              state_next.src_sel  = (src_code_in[1:0] == ccd_pkg::SHORT_SRC_STATIC)
                                    ? ccd_pkg::BASE_STATIC : ccd_pkg::BASE_FRAME;
              len = ccd_pkg::BYTES_TWO;
              cyc = ccd_pkg::CYC_THREE;
            end
            default: begin
              state_next.src_kind = ccd_pkg::KIND_ABS;
              len = ccd_pkg::BYTES_THREE;
              cyc = ccd_pkg::CYC_THREE;
            end
          endcase
        end
        ccd_pkg::DECIMAL_ADD_CARRY_OP, ccd_pkg::DECIMAL_ADD_OP,
        ccd_pkg::DECIMAL_SUB_BORROW_OP: begin
          // Operands are fixed: accumulator with its pair register (word) or its high half (byte), or an immediate
          state_next.src_kind = imm_in ? ccd_pkg::KIND_IMM : ccd_pkg::KIND_DATA;
          state_next.src_sel  = word_in ? 2'h1 : 2'h0;
          state_next.src_high = !word_in && !imm_in;
          if (imm_in) begin
            len = word_in ? ccd_pkg::BYTES_FOUR : ccd_pkg::BYTES_THREE;
          end else begin
            len = ccd_pkg::BYTES_TWO;
          end
          cyc = (op_in == ccd_pkg::DECIMAL_SUB_BORROW_OP) ? ccd_pkg::CYC_DEC_SUB
                                                         : ccd_pkg::CYC_DEC_ADD;
        end
        ccd_pkg::DECREMENT_OP: begin
          if (word_in) begin
            state_next.dst_kind = ccd_pkg::KIND_ADDR;
            state_next.dst_sel  = {1'b0, dst_code_in[0]};
            len = ccd_pkg::BYTES_ONE;
            cyc = ccd_pkg::CYC_ONE;
          end else begin
            case (dst_code_in[2:0])
              ccd_pkg::DEC_HIGH_HALF, ccd_pkg::DEC_LOW_HALF: begin
                state_next.dst_high = (dst_code_in[2:0] == ccd_pkg::DEC_HIGH_HALF);
                len = ccd_pkg::BYTES_ONE;
                cyc = ccd_pkg::CYC_ONE;
              end
              ccd_pkg::DEC_STATIC, ccd_pkg::DEC_FRAME: begin
                state_next.dst_kind = ccd_pkg::KIND_DSP8;
                state_next.dst_sel  = (dst_code_in[2:0] == ccd_pkg::DEC_STATIC)
                                      ? ccd_pkg::BASE_STATIC : ccd_pkg::BASE_FRAME;
                len = ccd_pkg::BYTES_TWO;
                cyc = ccd_pkg::CYC_THREE;
              end
              ccd_pkg::DEC_ABS: begin
                state_next.dst_kind = ccd_pkg::KIND_ABS;
                len = ccd_pkg::BYTES_THREE;
                cyc = ccd_pkg::CYC_THREE;
              end
              default: begin
                state_next.bad_code = 1'b1;      // Codes 000-010 are not defined
              end
            endcase
          end
        end
        ccd_pkg::SIGNED_DIVIDE_OP, ccd_pkg::SIGNED_DIVIDE_ALT_OP,
        ccd_pkg::UNSIGNED_DIVIDE_OP: begin
          state_next.is_div = 1'b1;
          if (imm_in) begin
            state_next.src_kind = ccd_pkg::KIND_IMM;
            len = word_in ? ccd_pkg::BYTES_FOUR : ccd_pkg::BYTES_THREE;
          end else begin
            state_next.src_kind = gsrc_kind;
            state_next.src_sel  = gsrc_sel;
            state_next.src_high = gsrc_high;
            len = 3'(ccd_pkg::BYTES_TWO + ccd_pkg::ext_bytes(gsrc_kind));
          end
          if (op_in == ccd_pkg::UNSIGNED_DIVIDE_OP) begin
            cyc = (!imm_in && ccd_pkg::is_mem(gsrc_kind)) ? ccd_pkg::CYC_UDIV_MEM
                                                          : ccd_pkg::CYC_UDIV_REG;
            cyc = 5'(cyc + (word_in ? ccd_pkg::CYC_UDIV_WORD : 5'h00));
          end else begin
            cyc = (!imm_in && ccd_pkg::is_mem(gsrc_kind)) ? ccd_pkg::CYC_SDIV_MEM
                                                          : ccd_pkg::CYC_SDIV_REG;
            cyc = 5'(cyc + (word_in ? ccd_pkg::CYC_SDIV_WORD : 5'h00));
          end
        end
        default: begin
          state_next.bad_code = 1'b1;
        end
      endcase
      state_next.bytes  = len;
      state_next.cycles = cyc;
      state_next.left   = cyc;
      // An undefined encoding is flagged and never starts execution
      state_next.st     = state_next.bad_code ? ST_IDLE : ST_EXEC;
    end else begin
      case (state_reg.st)
        ST_EXEC: begin
          // Divider may stop short; the count is only a ceiling
          if (state_reg.left <= 5'h01 ||
              (state_reg.is_div && early_done_in)) begin
            state_next.st   = ST_IDLE;
            state_next.done = 1'b1;
            state_next.left = 5'h00;
          end else begin
            state_next.left = state_reg.left - 5'h01;
          end
        end
        default: begin
          state_next.st = ST_IDLE;
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign busy_out        = (state_reg.st == ST_EXEC);
  assign done_out        = state_reg.done;
  assign bytes_out       = state_reg.bytes;
  assign cycles_out      = state_reg.cycles;
  assign writes_dest_out = state_reg.writes_dest;
  assign bad_code_out    = state_reg.bad_code;
  assign src_kind_out    = state_reg.src_kind;
  assign src_sel_out     = state_reg.src_sel;
  assign src_high_out    = state_reg.src_high;
  assign dst_kind_out    = state_reg.dst_kind;
  assign dst_sel_out     = state_reg.dst_sel;
  assign dst_high_out    = state_reg.dst_high;

  // Checks on the decoded results and the execution timing
  default clocking ccd_cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_cmp_no_write: assert property (
    take && op_in inside {ccd_pkg::COMPARE_G_OP, ccd_pkg::COMPARE_S_OP}
    |=> !writes_dest_out) else $error("compare would write its destination");

  a_cmp_reg_time: assert property (
    take && op_in == ccd_pkg::COMPARE_G_OP && src_code_in <= 4'h5 && dst_code_in <= 4'h5
    |=> busy_out && cycles_out == 5'h02 ##1 busy_out ##1 !busy_out && done_out)
    else $error("register compare not two cycles");

  a_cmp_mem_both: assert property (
    take && op_in == ccd_pkg::COMPARE_G_OP && src_code_in >= 4'h6 && dst_code_in >= 4'h6
    |=> cycles_out == 5'h04) else $error("memory compare not four cycles");

  a_cmp_abs_len: assert property (
    take && op_in == ccd_pkg::COMPARE_G_OP && src_code_in == 4'hF && dst_code_in == 4'hF
    |=> bytes_out == 3'h6) else $error("absolute compare length wrong");

  a_byte_half_sel: assert property (
    take && op_in == ccd_pkg::COMPARE_G_OP && !word_in && src_code_in == 4'h3
    |=> src_kind_out == ccd_pkg::KIND_DATA && src_sel_out == 2'h1 && src_high_out)
    else $error("byte register half decode wrong");

  a_short_abs: assert property (
    take && op_in == ccd_pkg::COMPARE_S_OP && src_code_in[1:0] == 2'h3
    |=> bytes_out == 3'h3 && cycles_out == 5'h03) else $error("short compare abs wrong");

  a_decimal_time: assert property (
    take && op_in inside {ccd_pkg::DECIMAL_ADD_CARRY_OP, ccd_pkg::DECIMAL_SUB_BORROW_OP}
    |=> cycles_out == (($past(op_in) == ccd_pkg::DECIMAL_SUB_BORROW_OP) ? 5'h04 : 5'h05))
    else $error("decimal cycle count wrong");

  a_dec_reg_fast: assert property (
    take && op_in == ccd_pkg::DECREMENT_OP && !word_in && dst_code_in[2:0] == 3'h3
    |=> bytes_out == 3'h1 && cycles_out == 5'h01 && dst_high_out ##1 done_out)
    else $error("register decrement timing wrong");

  a_udiv_word_imm: assert property (
    take && op_in == ccd_pkg::UNSIGNED_DIVIDE_OP && imm_in && word_in
    |=> bytes_out == 3'h4 && cycles_out == 5'h19) else $error("unsigned divide word wrong");

  a_sdiv_mem_word: assert property (
    take && op_in == ccd_pkg::SIGNED_DIVIDE_ALT_OP && !imm_in && word_in && src_code_in >= 4'h6
    |=> cycles_out == 5'h1E) else $error("signed divide memory word wrong");

  a_div_bound: assert property (
    take && op_in inside {ccd_pkg::SIGNED_DIVIDE_OP, ccd_pkg::UNSIGNED_DIVIDE_OP}
    |-> ##[2:32] done_out) else $error("divide overran its count");

  c_cmp_general: cover property (take && op_in == ccd_pkg::COMPARE_G_OP ##[1:8] done_out);
  c_div_early:   cover property (busy_out && state_reg.is_div && early_done_in ##1 done_out);
  c_bad_code:    cover property (bad_code_out);

endmodule : ccd_decode_timer

`default_nettype wire

/* ccd_operand_decode.sv */
/*
  Shared constants for the compare / decimal / divide decode slice, and the
  4-bit general operand field decoder used for source and destination.
  Assumes the instruction word has been split into fields by fetch logic.
*/
`timescale 1ns/1ns
`default_nettype none

package ccd_pkg;

  // Instruction classes presented by fetch
  typedef enum logic [3:0] {
    COMPARE_G_OP            = 4'h0,
    COMPARE_S_OP            = 4'h1,
    DECIMAL_ADD_CARRY_OP    = 4'h2,
    DECIMAL_ADD_OP          = 4'h3,
    DECIMAL_SUB_BORROW_OP   = 4'h4,
    DECREMENT_OP            = 4'h5,
    SIGNED_DIVIDE_OP        = 4'h6,
    SIGNED_DIVIDE_ALT_OP    = 4'h7,
    UNSIGNED_DIVIDE_OP      = 4'h8
  } ccd_op_e;

  // Operand kinds after decode
  typedef enum logic [2:0] {
    KIND_DATA  = 3'h0,
    KIND_ADDR  = 3'h1,
    KIND_IND   = 3'h2,
    KIND_DSP8  = 3'h3,
    KIND_DSP16 = 3'h4,
    KIND_ABS   = 3'h5,
    KIND_IMM   = 3'h6,
    KIND_NONE  = 3'h7
  } ccd_kind_e;

  // Base selector for indirect and displacement kinds
  localparam logic [1:0] BASE_ADDRESS_REG_ZERO = 2'h0;
  localparam logic [1:0] BASE_ADDRESS_REG_ONE  = 2'h1;
  localparam logic [1:0] BASE_STATIC           = 2'h2;
  localparam logic [1:0] BASE_FRAME            = 2'h3;

  // Field codes of the general operand field
  localparam logic [3:0] CODE_LAST_DATA   = 4'h3;
  localparam logic [3:0] CODE_LAST_ADDR   = 4'h5;
  localparam logic [3:0] CODE_LAST_IND    = 4'h7;
  localparam logic [3:0] CODE_LAST_DSP8   = 4'hB;
  localparam logic [3:0] CODE_STATIC_D16  = 4'hE;
  localparam logic [3:0] CODE_ABSOLUTE    = 4'hF;

  // Short compare source codes, byte decrement destination codes
  localparam logic [1:0] SHORT_SRC_REG    = 2'h0;
  localparam logic [1:0] SHORT_SRC_STATIC = 2'h1;
  localparam logic [1:0] SHORT_SRC_FRAME  = 2'h2;
  localparam logic [1:0] SHORT_SRC_ABS    = 2'h3;
  localparam logic [2:0] DEC_HIGH_HALF    = 3'h3;
  localparam logic [2:0] DEC_LOW_HALF     = 3'h4;
  localparam logic [2:0] DEC_STATIC       = 3'h5;
  localparam logic [2:0] DEC_FRAME        = 3'h6;
  localparam logic [2:0] DEC_ABS          = 3'h7;

  // Byte counts
  localparam logic [2:0] BYTES_ONE        = 3'h1;
  localparam logic [2:0] BYTES_TWO        = 3'h2;
  localparam logic [2:0] BYTES_THREE      = 3'h3;
  localparam logic [2:0] BYTES_FOUR       = 3'h4;

  // Cycle counts (byte size; word extras separate)
  localparam logic [4:0] CYC_ONE          = 5'h01;
  localparam logic [4:0] CYC_CMP_REG      = 5'h02;
  localparam logic [4:0] CYC_THREE        = 5'h03;
  localparam logic [4:0] CYC_DEC_ADD      = 5'h05;
  localparam logic [4:0] CYC_DEC_SUB      = 5'h04;
  localparam logic [4:0] CYC_SDIV_REG     = 5'h16;
  localparam logic [4:0] CYC_SDIV_MEM     = 5'h18;
  localparam logic [4:0] CYC_SDIV_WORD    = 5'h06;
  localparam logic [4:0] CYC_UDIV_REG     = 5'h12;
  localparam logic [4:0] CYC_UDIV_MEM     = 5'h14;
  localparam logic [4:0] CYC_UDIV_WORD    = 5'h07;

  // Extension bytes that an operand kind adds to the instruction
  function automatic logic [2:0] ext_bytes(input ccd_kind_e kind);
    case (kind)
      KIND_DSP8:  ext_bytes = 3'h1;
      KIND_DSP16: ext_bytes = 3'h2;
      KIND_ABS:   ext_bytes = 3'h2;
      default:    ext_bytes = 3'h0;
    endcase
  endfunction : ext_bytes

  // Whether an operand kind lives in memory
  function automatic logic is_mem(input ccd_kind_e kind);
    is_mem = (kind == KIND_IND) || (kind == KIND_DSP8) ||
             (kind == KIND_DSP16) || (kind == KIND_ABS);
  endfunction : is_mem

endpackage : ccd_pkg

module ccd_operand_decode (
  // Field
  input  wire logic [3:0]       code_in,
  input  wire logic             word_in,
  // Decoded operand
  output ccd_pkg::ccd_kind_e    kind_out,
  output logic [1:0]            sel_out,
  output logic                  high_out
);

  // Pure decode; the caller registers the result
  always_comb begin
    sel_out  = code_in[1:0];
    high_out = 1'b0;
    if (code_in <= ccd_pkg::CODE_LAST_DATA) begin
      kind_out = ccd_pkg::KIND_DATA;
      if (!word_in) begin
        sel_out  = {1'b0, code_in[1]};   // Byte: halves of first two registers
        high_out = code_in[0];
      end
    end else if (code_in <= ccd_pkg::CODE_LAST_ADDR) begin
      kind_out = ccd_pkg::KIND_ADDR;
      sel_out  = {1'b0, code_in[0]};
    end else if (code_in <= ccd_pkg::CODE_LAST_IND) begin
      kind_out = ccd_pkg::KIND_IND;
      sel_out  = {1'b0, code_in[0]};
    end else if (code_in <= ccd_pkg::CODE_LAST_DSP8) begin
      kind_out = ccd_pkg::KIND_DSP8;
    end else if (code_in == ccd_pkg::CODE_ABSOLUTE) begin
      kind_out = ccd_pkg::KIND_ABS;
      sel_out  = 2'h0;
    end else begin
      kind_out = ccd_pkg::KIND_DSP16;
      sel_out  = (code_in == ccd_pkg::CODE_STATIC_D16) ? ccd_pkg::BASE_STATIC
                                                       : {1'b0, code_in[0]};
    end
  end

endmodule : ccd_operand_decode

`default_nettype wire

/* ccd_decode_timer_tb.sv */
/*
  Self-checking bench for ccd_decode_timer: corner sweeps and seeded random issues.
  Assumes ccd_pkg and the design files are compiled ahead of this file.
*/
`timescale 1ns/1ns
`default_nettype none

module ccd_decode_timer_tb;
  logic               clk_in = 1'b0;
  logic               reset_in = 1'b1;
  logic               issue_in = 1'b0;
  logic [3:0]         op_in = 4'h0;
  logic               word_in = 1'b0;
  logic               imm_in = 1'b0;
  logic [3:0]         src_code_in = 4'h0;
  logic [3:0]         dst_code_in = 4'h0;
  logic               early_done_in = 1'b0;
  logic               busy_out, done_out, writes_dest_out, bad_code_out;
  logic [2:0]         bytes_out;
  logic [4:0]         cycles_out;
  ccd_pkg::ccd_kind_e src_kind_out, dst_kind_out;
  logic [1:0]         src_sel_out, dst_sel_out;
  logic               src_high_out, dst_high_out;
  int                 n_errors = 0;
  int                 total_checks = 0;

  ccd_decode_timer dut_u (.clk_in(clk_in), .reset_in(reset_in), .issue_in(issue_in),
    .op_in(op_in), .word_in(word_in), .imm_in(imm_in), .src_code_in(src_code_in),
    .dst_code_in(dst_code_in), .early_done_in(early_done_in), .busy_out(busy_out),
    .done_out(done_out), .bytes_out(bytes_out), .cycles_out(cycles_out),
    .writes_dest_out(writes_dest_out), .bad_code_out(bad_code_out),
    .src_kind_out(src_kind_out), .src_sel_out(src_sel_out), .src_high_out(src_high_out),
    .dst_kind_out(dst_kind_out), .dst_sel_out(dst_sel_out), .dst_high_out(dst_high_out));

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  // Counts every compare; four-state so an unknown never matches
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Extension bytes of a general operand field
  function automatic int xb(input logic [3:0] c);
    return (c >= 4'hC) ? 2 : (c >= 4'h8) ? 1 : 0;
  endfunction : xb

  function automatic ccd_pkg::ccd_kind_e kof(input logic [3:0] c);
    if (c < 4'h4) return ccd_pkg::KIND_DATA;
    if (c < 4'h6) return ccd_pkg::KIND_ADDR;
    if (c < 4'h8) return ccd_pkg::KIND_IND;
    if (c < 4'hC) return ccd_pkg::KIND_DSP8;
    return (c == 4'hF) ? ccd_pkg::KIND_ABS : ccd_pkg::KIND_DSP16;
  endfunction : kof

  // Register index or base: byte codes pair up as low/high halves
  function automatic logic [1:0] sf(input logic [3:0] c, input logic w);
    if (c < 4'h4) return w ? c[1:0] : {1'b0, c[1]};
    return (c < 4'h8) ? {1'b0, c[0]} : c[1:0];
  endfunction : sf

  // Fixed source of the decimal forms: immediate, or pair register / high half
  function automatic logic [5:0] pk(input logic w, input logic i);
    return {(i ? ccd_pkg::KIND_IMM : ccd_pkg::KIND_DATA), 1'b0, w, !w && !i};
  endfunction : pk

  // Decrement destination as kind, register or base, and half
  function automatic logic [5:0] dk(input logic w, input logic [2:0] d);
    if (w) return {ccd_pkg::KIND_ADDR, 1'b0, d[0], 1'b0};
    if (d < 3'h5) return {ccd_pkg::KIND_DATA, 2'h0, d == 3'h3};
    if (d == 3'h7) return {ccd_pkg::KIND_ABS, 2'h0, 1'b0};
    return {ccd_pkg::KIND_DSP8,
            (d == 3'h5) ? ccd_pkg::BASE_STATIC : ccd_pkg::BASE_FRAME, 1'b0};
  endfunction : dk

  // Expected length, nominal cycles, destination write and refusal
  function automatic void calc(input int op, input logic w, input logic i,
                               input logic [3:0] s, input logic [3:0] d,
                               output int b, output int cy, output logic wd, output logic bad);
    b = 0;
    cy = 0;
    wd = 1'b1;
    bad = 1'b0;
    case (op)
      0: begin
        b = 2 + xb(s) + xb(d);
        cy = 2 + int'(s >= 4'h6) + int'(d >= 4'h6);
        wd = 1'b0;
      end
      1: begin
        b = (s[1:0] == 2'h3) ? 3 : (s[1:0] == 2'h0) ? 1 : 2;
        cy = (s[1:0] == 2'h0) ? 2 : 3;
        wd = 1'b0;
      end
      2, 3, 4: begin
        b = i ? 3 + int'(w) : 2;
        cy = (op == 4) ? 4 : 5;
      end
      5: begin
        bad = !w && d[2:0] < 3'h3;
        b = (w || d[2:0] < 3'h5) ? 1 : (d[2:0] == 3'h7) ? 3 : 2;
        cy = (b == 1) ? 1 : 3;
      end
      6, 7, 8: begin
        b = i ? 3 + int'(w) : 2 + xb(s);
        cy = ((op == 8) ? 18 : 22) + 2 * int'(!i && s >= 4'h6) + ((op == 8) ? 7 : 6) * int'(w);
      end
      default: bad = 1'b1;
    endcase
  endfunction : calc

  // One issue, then count busy cycles; e is the cycle showing an early divide end
  task automatic run(input int op, input logic w, input logic i, input logic [3:0] s,
                     input logic [3:0] d, input int e, input logic intr);
    int   b, cy, n, ecy;
    logic wd, bad;
    calc(op, w, i, s, d, b, cy, wd, bad);
    ecy = (op >= 6 && op <= 8 && e > 0 && e < cy) ? e : cy;
    @(posedge clk_in);
    issue_in <= 1'b1;
    op_in <= 4'(op);
    word_in <= w;
    imm_in <= i;
    src_code_in <= s;
    dst_code_in <= d;
    early_done_in <= 1'b0;
    @(posedge clk_in);
    issue_in <= 1'b0;
    #1;
    chk("bad_code", bad_code_out, bad);
    if (bad) begin
      chk("busy_refused", busy_out, 0);
      return;
    end
    chk("bytes", bytes_out, b);
    chk("cycles", cycles_out, cy);
    chk("writes_dest", writes_dest_out, wd);
    if (op == 0) begin
      chk("src_kind", src_kind_out, kof(s));
      chk("dst_kind", dst_kind_out, kof(d));
      if (s != 4'hF) chk("src_sel", src_sel_out, sf(s, w));
      if (d != 4'hF) chk("dst_sel", dst_sel_out, sf(d, w));
      if (s < 4'h4) chk("src_high", src_high_out, !w && s[0]);
      if (d < 4'h4) chk("dst_high", dst_high_out, !w && d[0]);
    end
    if (op == 1) begin
      chk("short_dst_high", dst_high_out, d[0]);
      if (s[1:0] == 2'h0) chk("short_src_high", src_high_out, !d[0]);
      if (s[1:0] == 2'h1) chk("short_src_sel", src_sel_out, ccd_pkg::BASE_STATIC);
    end
    if (op inside {2, 3, 4}) begin
      chk("pair", {src_kind_out, src_sel_out, src_high_out}, pk(w, i));
    end
    if (op == 5) begin
      chk("dec_dst", {dst_kind_out, dst_sel_out, dst_high_out}, dk(w, d[2:0]));
    end
    if (op >= 6 && op <= 8) begin
      chk("div_src", src_kind_out, i ? ccd_pkg::KIND_IMM : kof(s));
    end
    // A second issue inside the run must be ignored, so it only goes in when busy lasts
    n = 0;
    while (busy_out === 1'b1 && n < 40) begin
      n++;
      @(posedge clk_in);
      early_done_in <= (n + 1 == e);
      issue_in <= intr && n == 1 && cy > 2;
      #1;
    end
    chk("busy_cycles", n, ecy);
    if (n >= 40) conclude();
    chk("done", done_out, 1);
    @(posedge clk_in);
    #1;
    chk("done_pulse", done_out, 0);
  endtask : run

  initial begin
    int seed_sink;
    seed_sink = $urandom(96645);
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    #1;
    chk("busy_reset", busy_out, 0);
    // Hand-picked corners the sweep never forms: register pair, absolute pair, byte high-half source
    run(0, 1'b0, 1'b0, 4'h1, 4'h4, 0, 1'b1);
    run(0, 1'b0, 1'b0, 4'hF, 4'hF, 0, 1'b0);
    run(0, 1'b0, 1'b0, 4'h3, 4'h2, 0, 1'b0);
    // Every class against every field code, size and form
    for (int op = 0; op < 16; op++) begin
      for (int k = 0; k < 16; k++) begin
        run(op, k[0], k[1], 4'(k), 4'(15 - k), (k == 3) ? 6 : 0, k == 5);
      end
    end
    $display("corner sweep done, mismatches %0d", n_errors);
    // Random issues with early divide ends and refused mid-run issues
    repeat (200) begin
      run($urandom_range(0, 9), 1'($urandom), 1'($urandom), 4'($urandom), 4'($urandom),
          $urandom_range(2, 30), 1'($urandom));
    end
    $display("random run done, mismatches %0d", n_errors);
    conclude();
  end
endmodule : ccd_decode_timer_tb

`default_nettype wire
